/* File: tpo_pkg.sv */
// constants shared by the timing pattern output controller
package tpo_pkg;

	// structure
	localparam int GRP_W   = 4;
	localparam int NUM_GRP = 4;
	localparam int PIN_W   = 16;
	localparam int SEL_W   = 2;
	localparam int NUM_CH  = 4;
	localparam int REG_W   = 8;
	localparam int ADR_W   = 18;
	localparam int DAT_W   = 32;
	localparam int FIFO_D  = 8;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_MODE    = 16'hffa0;
	localparam logic [15:0] IDX_TSEL    = 16'hffa1;
	localparam logic [15:0] IDX_ENH     = 16'hffa2;
	localparam logic [15:0] IDX_ENL     = 16'hffa3;
	localparam logic [15:0] IDX_NDH     = 16'hffa4;
	localparam logic [15:0] IDX_NDL     = 16'hffa5;
	localparam logic [15:0] IDX_NDH_ALT = 16'hffa6;
	localparam logic [15:0] IDX_NDL_ALT = 16'hffa7;
	localparam logic [15:0] IDX_DIRA    = 16'hffd1;
	localparam logic [15:0] IDX_PDA     = 16'hffd3;
	localparam logic [15:0] IDX_DIRB    = 16'hffd4;
	localparam logic [15:0] IDX_PDB     = 16'hffd6;

	// reset and fixed read values
	localparam logic [7:0] RST_MODE  = 8'hf0;
	localparam logic [7:0] RST_TSEL  = 8'hff;
	localparam logic [7:0] RST_ZERO  = 8'h00;
	localparam logic [7:0] RSVD_ONES = 8'hff;
	localparam logic [3:0] NIB_ONES  = 4'hf;
	localparam logic [3:0] MODE_FIX  = 4'hf;

endpackage

/* File: tpo_controller.sv */
// pattern fifo and timing pattern output controller with wishbone registers
`timescale 1ns/1ps

// simple synchronous fifo; depth must be a power of two
module tpo_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = AW'(0) + (AW+1)'(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	// honest flags straight from the count
	assign in_ready_o  = cnt_reg != FULL;
	assign out_valid_o = cnt_reg != '0;
	assign out_data_o  = mem[rp_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// storage; no reset needed for data words
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_reg] <= in_data_i;
		end
	end

	// pointers wrap naturally at a power-of-two depth
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= wp_reg + AW'(1);
			end
			if (pop) begin
				rp_reg <= rp_reg + AW'(1);
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Notes on behaviour
// - The outputs form four 4-bit groups, 3 to 0, each running on its own.
// - Up to 16 pattern bits are driven and each bit has its own output enable.
// - Each group picks its trigger from the compare matches of four timer channels.
// - A non-overlap mode separates falling and rising edges by two compare events.
// - A compare match b chosen as a trigger also raises a dma request; a match a never does.
// - Pins 0-3 are group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3.
// - Each direction register is 8-bit, write-only and cleared at reset.
// - Port data bits enabled for pattern output ignore processor writes.
// - Low next data sits at ffa5 when groups 0 and 1 share a trigger, else split ffa5/ffa7.
// - High next data sits at ffa4 when groups 2 and 3 share a trigger, else split ffa4/ffa6.
// - On the selected match each enabled next-data bit is copied to its port data bit.
// - Next-data halves left unused by the mapping ignore writes and read as ones.
// - Next data and enables clear on reset and hardware standby, not software standby.
module tpo_controller (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [tpo_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [tpo_pkg::DAT_W-1:0]  wb_dat_i,
	output logic [tpo_pkg::DAT_W-1:0]       wb_dat_o,
	output logic                            wb_ack_o,
	// timer compare match pulses, one per channel
	input  wire logic [tpo_pkg::NUM_CH-1:0] cmp_a_i,
	input  wire logic [tpo_pkg::NUM_CH-1:0] cmp_b_i,
	input  wire logic                       hw_standby_i,
	// pattern word stream
	input  wire logic                       pat_valid_i,
	output logic                            pat_ready_o,
	input  wire logic [tpo_pkg::PIN_W-1:0]  pat_data_i,
	// pins and dma
	output logic [tpo_pkg::PIN_W-1:0]       pattern_out_pin_o,
	output logic [tpo_pkg::PIN_W-1:0]       pin_oe_n_o,
	output logic [tpo_pkg::NUM_CH-1:0]      dma_req_o
);
	localparam int G = tpo_pkg::GRP_W;
	localparam int B = tpo_pkg::REG_W;

	logic [G-1:0]                   mode_reg;
	logic [B-1:0]                   tsel_reg;
	logic [tpo_pkg::PIN_W-1:0]      en_reg;
	logic [tpo_pkg::PIN_W-1:0]      nd_reg;
	logic [tpo_pkg::PIN_W-1:0]      dir_reg;
	logic [tpo_pkg::PIN_W-1:0]      pd_reg;
	logic [tpo_pkg::PIN_W-1:0]      pd_next;
	logic [tpo_pkg::PIN_W-1:0]      xfer_mask;
	logic [tpo_pkg::NUM_GRP-1:0]    fire_b;
	logic [tpo_pkg::NUM_GRP-1:0]    fire_a;
	logic [tpo_pkg::NUM_CH-1:0]     dma_next;
	logic [tpo_pkg::DAT_W-1:0]      rd_next;
	logic [B-1:0]                   rd_byte;
	logic [B-1:0]                   wdat;
	logic [15:0]                    idx;
	logic                           ack_reg;
	logic                           req;
	logic                           wr_go;
	logic                           same_low;
	logic                           same_high;
	logic                           pend_reg;
	logic                           f_valid;
	logic                           pop;
	logic [tpo_pkg::PIN_W-1:0]      f_data;

	// bus decode; ack is registered so writes land on the acked edge
	assign idx      = wb_adr_i[tpo_pkg::ADR_W-1:2];
	assign wdat     = wb_dat_i[B-1:0];
	assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ack_reg;
	assign wb_ack_o = ack_reg;

	// groups sharing a trigger decide the next-data layout
	assign same_low  = tsel_reg[1:0] == tsel_reg[3:2];
	assign same_high = tsel_reg[5:4] == tsel_reg[7:6];

	// per-group trigger pick and transfer mask
	// group slices
	for (genvar g = 0; g < tpo_pkg::NUM_GRP; g++) begin : g_grp
		logic [tpo_pkg::SEL_W-1:0] sel;
		logic [G-1:0]              en;
		logic [G-1:0]              nd;
		assign sel       = tsel_reg[g*tpo_pkg::SEL_W +: tpo_pkg::SEL_W];
		assign en        = en_reg[g*G +: G];
		assign nd        = nd_reg[g*G +: G];
		assign fire_b[g] = cmp_b_i[sel];
		assign fire_a[g] = cmp_a_i[sel];
		// non-overlap: zeros go out on match b, ones on match a
		assign xfer_mask[g*G +: G] = mode_reg[g]
			? (({G{fire_b[g]}} & en & ~nd) | ({G{fire_a[g]}} & en & nd))
			: ({G{fire_b[g]}} & en);
	end

	always_comb begin
		pd_next = (pd_reg & ~xfer_mask) | (nd_reg & xfer_mask);
		if (wr_go && idx == tpo_pkg::IDX_PDA) begin
			pd_next[7:0] = (pd_next[7:0] & en_reg[7:0]) | (wdat & ~en_reg[7:0]);
		end
		if (wr_go && idx == tpo_pkg::IDX_PDB) begin
			pd_next[15:8] = (pd_next[15:8] & en_reg[15:8]) | (wdat & ~en_reg[15:8]);
		end
	end

	always_comb begin
		dma_next = '0;
		for (int g = 0; g < tpo_pkg::NUM_GRP; g++) begin
			if (fire_b[g]) begin
				dma_next[tsel_reg[g*tpo_pkg::SEL_W +: tpo_pkg::SEL_W]] = 1'b1;
			end
		end
	end

	// read mux; write-only and unmapped words read zero
	always_comb begin
		rd_byte = tpo_pkg::RST_ZERO;
		case (idx)
			tpo_pkg::IDX_MODE: rd_byte = {tpo_pkg::MODE_FIX, mode_reg};
			tpo_pkg::IDX_TSEL: rd_byte = tsel_reg;
			tpo_pkg::IDX_ENH:  rd_byte = en_reg[15:8];
			tpo_pkg::IDX_ENL:  rd_byte = en_reg[7:0];
			tpo_pkg::IDX_NDH:
				rd_byte = same_high ? nd_reg[15:8] : {nd_reg[15:12], tpo_pkg::NIB_ONES};
			tpo_pkg::IDX_NDH_ALT:
				rd_byte = same_high ? tpo_pkg::RSVD_ONES : {tpo_pkg::NIB_ONES, nd_reg[11:8]};
			tpo_pkg::IDX_NDL:
				rd_byte = same_low ? nd_reg[7:0] : {nd_reg[7:4], tpo_pkg::NIB_ONES};
			tpo_pkg::IDX_NDL_ALT:
				rd_byte = same_low ? tpo_pkg::RSVD_ONES : {tpo_pkg::NIB_ONES, nd_reg[3:0]};
			tpo_pkg::IDX_PDA:  rd_byte = pd_reg[7:0];
			tpo_pkg::IDX_PDB:  rd_byte = pd_reg[15:8];
			default:           rd_byte = tpo_pkg::RST_ZERO;
		endcase
		rd_next = {{(tpo_pkg::DAT_W-B){1'b0}}, rd_byte};
	end

	// ack and read data; ack drops the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg  <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			ack_reg <= req;
			if (req) begin
				wb_dat_o <= rd_next;
			end
		end
	end

	// mode and trigger select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= tpo_pkg::RST_MODE[G-1:0];
			tsel_reg <= tpo_pkg::RST_TSEL;
		end else if (wr_go) begin
			if (idx == tpo_pkg::IDX_MODE) begin
				mode_reg <= wdat[G-1:0];
			end
			if (idx == tpo_pkg::IDX_TSEL) begin
				tsel_reg <= wdat;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_reg <= {tpo_pkg::RST_ZERO, tpo_pkg::RST_ZERO};
		end else if (wr_go) begin
			if (idx == tpo_pkg::IDX_DIRA) begin
				dir_reg[7:0] <= wdat;
			end
			if (idx == tpo_pkg::IDX_DIRB) begin
				dir_reg[15:8] <= wdat;
			end
		end
	end

	// reload request: set by a transfer, cleared by a fifo pop, set wins
	assign pop = pend_reg & f_valid;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_reg <= 1'b0;
		end else begin
			pend_reg <= (|fire_b) | (pend_reg & ~pop);
		end
	end

	// enables and next data, cleared by standby
	// a bus write after a pop in the same cycle wins for the bits it writes
	always_ff @(posedge clk_i) begin
		if (rst_i || hw_standby_i) begin
			en_reg <= {tpo_pkg::RST_ZERO, tpo_pkg::RST_ZERO};
			nd_reg <= {tpo_pkg::RST_ZERO, tpo_pkg::RST_ZERO};
		end else begin
			if (pop) begin
				nd_reg <= f_data;
			end
			if (wr_go) begin
				case (idx)
					tpo_pkg::IDX_ENH: en_reg[15:8] <= wdat;
					tpo_pkg::IDX_ENL: en_reg[7:0] <= wdat;
					tpo_pkg::IDX_NDH: begin
						if (same_high) begin
							nd_reg[15:8] <= wdat;
						end else begin
							nd_reg[15:12] <= wdat[7:4];
						end
					end
					tpo_pkg::IDX_NDH_ALT: begin
						if (!same_high) begin
							nd_reg[11:8] <= wdat[3:0];
						end
					end
					tpo_pkg::IDX_NDL: begin
						if (same_low) begin
							nd_reg[7:0] <= wdat;
						end else begin
							nd_reg[7:4] <= wdat[7:4];
						end
					end
					tpo_pkg::IDX_NDL_ALT: begin
						if (!same_low) begin
							nd_reg[3:0] <= wdat[3:0];
						end
					end
					default: ;
				endcase
			end
		end
	end

	// port data and dma pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_reg    <= {tpo_pkg::RST_ZERO, tpo_pkg::RST_ZERO};
			dma_req_o <= '0;
		end else begin
			pd_reg    <= pd_next;
			dma_req_o <= dma_next;
		end
	end

	// pins follow port data, direction drives enable
	assign pattern_out_pin_o = pd_reg;
	assign pin_oe_n_o        = ~dir_reg;

	// pattern words wait here until a transfer asks for the next one
	tpo_fifo #(
		.W (tpo_pkg::PIN_W),
		.D (tpo_pkg::FIFO_D)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (pat_valid_i),
		.in_ready_o  (pat_ready_o),
		.in_data_i   (pat_data_i),
		.out_valid_o (f_valid),
		.out_ready_i (pend_reg),
		.out_data_o  (f_data)
	);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_xfer;
		(!mode_reg[0] && fire_b[0]) |=>
			((pattern_out_pin_o[3:0] ^ $past(nd_reg[3:0])) & $past(en_reg[3:0])) == '0;
	endproperty
	a_xfer: assert property (p_xfer) else $error("group 0 transfer missed");

	property p_ro_bits;
		(wr_go && idx == tpo_pkg::IDX_PDA && xfer_mask[7:0] == '0) |=>
			((pattern_out_pin_o[7:0] ^ $past(pd_reg[7:0])) & $past(en_reg[7:0])) == '0;
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("enabled bit was written");

	property p_dir_rst;
		// reset is the trigger here, so the default disable must not apply
		@(posedge clk_i) disable iff (1'b0) rst_i |=> pin_oe_n_o == '1;
	endproperty
	a_dir_rst: assert property (p_dir_rst) else $error("direction not cleared");

	property p_standby;
		hw_standby_i |=> (nd_reg == '0 && en_reg == '0) ##1 (en_reg == '0);
	endproperty
	a_standby: assert property (p_standby) else $error("standby did not clear");

	property p_rsvd_read;
		(req && !wb_we_i && idx == tpo_pkg::IDX_NDL_ALT && same_low) |=>
			wb_ack_o && wb_dat_o[7:0] == tpo_pkg::RSVD_ONES;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte not ones");

	property p_split_low;
		(wr_go && idx == tpo_pkg::IDX_NDL && !same_low && !pop) |=>
			nd_reg[3:0] == $past(nd_reg[3:0]) && nd_reg[7:4] == $past(wdat[7:4]);
	endproperty
	a_split_low: assert property (p_split_low) else $error("split layout wrong");

	property p_dma;
		cmp_b_i[tsel_reg[1:0]] |=> dma_req_o[$past(tsel_reg[1:0])] ##1 1'b1;
	endproperty
	a_dma: assert property (p_dma) else $error("dma request missing");

	property p_nov;
		(mode_reg[0] && fire_a[0] && !fire_b[0]) |=>
			((pattern_out_pin_o[3:0] ^ $past(pd_reg[3:0]))
			& $past(en_reg[3:0]) & ~$past(nd_reg[3:0])) == '0;
	endproperty
	a_nov: assert property (p_nov) else $error("non-overlap fell early");

	c_xfer: cover property (fire_b[0] && en_reg[3:0] != '0 && !mode_reg[0]);
	c_full: cover property (!pat_ready_o ##1 pop);
	c_split: cover property (wr_go && idx == tpo_pkg::IDX_NDL_ALT && !same_low);
endmodule

/* File: tpo_load_model.sv */
// behavioural model of the loads on the pattern pins
`timescale 1ns/1ps
module tpo_load_model (
	// pins from the controller
	input  wire logic [tpo_pkg::PIN_W-1:0] pin_i,
	input  wire logic [tpo_pkg::PIN_W-1:0] oe_n_i,
	// level seen by the loads
	output logic [tpo_pkg::PIN_W-1:0]      level_o
);
	// each pin on its own
	// undriven pins go to the pull-up, never keep the last driven level
	always_comb begin
		for (int i = 0; i < tpo_pkg::PIN_W; i++) begin
			level_o[i] = oe_n_i[i] ? 1'b1 : pin_i[i];
		end
	end
endmodule

/* File: tb_top.sv */
// self-checking bench for the pattern output controller
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [17:0] adr   = 18'h00000;
	logic [3:0]  sel   = 4'h0;
	logic [31:0] wdat  = 32'h00000000;
	logic [31:0] rdat;
	logic        ack;
	logic        hw_sb = 1'b0;
	logic        pvld  = 1'b0;
	logic        prdy;
	logic [3:0]  cmp_a = 4'h0;
	logic [3:0]  cmp_b = 4'h0;
	logic [3:0]  dma;
	logic [15:0] pdat  = 16'h0000;
	logic [15:0] pins;
	logic [15:0] oe_n;
	logic [15:0] lvl;
	int          error_cnt = 0;
	int          checked   = 0;

	// 200 MHz system clock
	always #2.5 clk_i = ~clk_i;

	tpo_controller dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .cmp_a_i(cmp_a), .cmp_b_i(cmp_b), .hw_standby_i(hw_sb),
		.pat_valid_i(pvld), .pat_ready_o(prdy), .pat_data_i(pdat),
		.pattern_out_pin_o(pins), .pin_oe_n_o(oe_n), .dma_req_o(dma));

	tpo_load_model load_u (.pin_i(pins), .oe_n_i(oe_n), .level_o(lvl));

	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// closing verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		sel  <= 4'hf;
		adr  <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		// no local limit: only the watchdog may end a hung wait
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		chk({15'h0000, ack}, 16'h0001);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask

	task automatic rc(input logic [15:0] idx, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask

	// one-cycle compare pulses; dma looked at in the cycle it stands
	task automatic trig(input logic [3:0] b, input logic [3:0] a, input logic [3:0] d);
		@(posedge clk_i);
		cmp_b <= b;
		cmp_a <= a;
		@(posedge clk_i);
		cmp_b <= 4'h0;
		cmp_a <= 4'h0;
		#1 chk({12'h000, dma}, {12'h000, d});
	endtask

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end

	// main sequence
	initial begin
		static logic [15:0] ri [13] = '{tpo_pkg::IDX_MODE, tpo_pkg::IDX_TSEL, tpo_pkg::IDX_ENH,
			tpo_pkg::IDX_ENL, tpo_pkg::IDX_NDH, tpo_pkg::IDX_NDL, tpo_pkg::IDX_NDH_ALT,
			tpo_pkg::IDX_NDL_ALT, tpo_pkg::IDX_DIRA, tpo_pkg::IDX_PDA, tpo_pkg::IDX_DIRB,
			tpo_pkg::IDX_PDB, 16'hff80};
		static logic [7:0]  re [13] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [15:0] w;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk(lvl, 16'hffff);
		for (int i = 0; i < 13; i++) rc(ri[i], re[i]);
		// reserved half with a shared trigger swallows writes
		wr(tpo_pkg::IDX_NDL_ALT, 8'h00);
		rc(tpo_pkg::IDX_NDL_ALT, 8'hff);
		rc(tpo_pkg::IDX_NDL, 8'h00);
		// software owns the direction bits
		wr(tpo_pkg::IDX_DIRA, 8'hff);
		wr(tpo_pkg::IDX_DIRB, 8'hff);
		rc(tpo_pkg::IDX_DIRA, 8'h00);
		wr(tpo_pkg::IDX_TSEL, 8'h00);
		chk(oe_n, 16'h0000);
		wr(tpo_pkg::IDX_ENL, 8'hff);
		wr(tpo_pkg::IDX_ENH, 8'hff);
		wr(tpo_pkg::IDX_NDL, 8'ha5);
		wr(tpo_pkg::IDX_NDH, 8'h3c);
		trig(4'h1, 4'h0, 4'h1);
		chk(lvl, 16'h3ca5);
		// enabled port bits refuse writes, others accept
		wr(tpo_pkg::IDX_PDA, 8'h00);
		rc(tpo_pkg::IDX_PDA, 8'ha5);
		wr(tpo_pkg::IDX_ENL, 8'h0f);
		wr(tpo_pkg::IDX_PDA, 8'h00);
		rc(tpo_pkg::IDX_PDA, 8'h05);
		wr(tpo_pkg::IDX_NDL, 8'hff);
		trig(4'h1, 4'h0, 4'h1);
		chk(lvl, 16'h3c0f);
		trig(4'h2, 4'h0, 4'h0);
		chk(lvl, 16'h3c0f);
		// split triggers move the halves apart
		wr(tpo_pkg::IDX_ENL, 8'hff);
		wr(tpo_pkg::IDX_TSEL, 8'h44);
		wr(tpo_pkg::IDX_NDL, 8'h6b);
		rc(tpo_pkg::IDX_NDL, 8'h6f);
		wr(tpo_pkg::IDX_NDL_ALT, 8'h29);
		rc(tpo_pkg::IDX_NDL_ALT, 8'hf9);
		wr(tpo_pkg::IDX_NDH, 8'hc7);
		rc(tpo_pkg::IDX_NDH, 8'hcf);
		wr(tpo_pkg::IDX_NDH_ALT, 8'h12);
		rc(tpo_pkg::IDX_NDH_ALT, 8'hf2);
		trig(4'h2, 4'h0, 4'h2);
		chk(lvl, 16'hcc6f);
		trig(4'h1, 4'h0, 4'h1);
		chk(lvl, 16'hc269);
		// hardware standby clears data and enables
		@(posedge clk_i);
		hw_sb <= 1'b1;
		@(posedge clk_i);
		hw_sb <= 1'b0;
		rc(tpo_pkg::IDX_ENL, 8'h00);
		rc(tpo_pkg::IDX_ENH, 8'h00);
		rc(tpo_pkg::IDX_NDL, 8'h0f);
		// non-overlap on group 0: rising bits on a, falling on b
		wr(tpo_pkg::IDX_ENL, 8'hff);
		wr(tpo_pkg::IDX_TSEL, 8'h00);
		wr(tpo_pkg::IDX_MODE, 8'h01);
		rc(tpo_pkg::IDX_MODE, 8'hf1);
		wr(tpo_pkg::IDX_NDL, 8'h0a);
		trig(4'h0, 4'h1, 4'h0);
		chk(lvl, 16'hc26b);
		trig(4'h1, 4'h0, 4'h1);
		chk(lvl, 16'hc20a);
		// fill the fifo to full, then drain it by triggers
		wr(tpo_pkg::IDX_MODE, 8'h00);
		wr(tpo_pkg::IDX_ENH, 8'hff);
		w = 16'h0000;
		for (int k = 0; k < 9; k++) begin
			w = w + 16'h1111;
			@(posedge clk_i);
			pvld <= 1'b1;
			pdat <= w;
		end
		@(posedge clk_i);
		pvld <= 1'b0;
		#1 chk({15'h0000, prdy}, 16'h0000);
		// the reload request left by earlier transfers took the first word at once,
		// so eight words wait; the last trigger repeats the final word
		w = 16'h1111;
		for (int k = 0; k < 10; k++) begin
			trig(4'h1, 4'h0, 4'h1);
			chk(lvl, w);
			if (k < 8) w = w + 16'h1111;
		end
		chk({15'h0000, prdy}, 16'h0001);
		finish_test();
	end
endmodule
